// ### common/desr_pkg.sv
// Constants and carrier types for the extended-status responder
package desr_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam logic [1:0] VIEW_FAULT = 2'h0;
  localparam logic [1:0] VIEW_OPER = 2'h1;
  localparam logic [1:0] VIEW_DIAG = 2'h2;
  localparam logic [1:0] VIEW_EXEC = 2'h3;
  localparam logic [7:0] BUS_IN_RST = 8'h00;
  localparam int unsigned VALID_BIT = 7;
  localparam logic [3:0] FRU_NONE = 4'h0;
  localparam logic [3:0] FRU_POWER = 4'h1;
  localparam logic [3:0] FRU_CONTROL = 4'h2;
  localparam logic [3:0] FRU_RW = 4'h4;
  localparam logic [3:0] FRU_MODULE = 4'h5;
  localparam logic [3:0] FRU_FAN = 4'h6;
  localparam logic [3:0] FRU_IO = 4'h7;
  localparam logic [3:0] FRU_PANEL = 4'h8;
  // Latch code value unconfirmed; kept as a parameter default only
  localparam logic [3:0] FRU_LATCH_DEFAULT = 4'h9;

  typedef struct packed {
    logic voltage;
    logic head_sel;
    logic write_prot;
    logic write_flt;
    logic first_seek;
    logic off_cyl;
    logic rd_and_wr;
  } desr_fault_s;

  typedef struct packed {
    logic tag_unit_sel;
    logic tag_sector;
    logic tag_ext;
    logic [9:0] bus_out;
  } desr_ctl_s;
endpackage : desr_pkg

// ### core/desr_responder.sv
// Extended-status and single-channel selection responder
`timescale 1ns/10ps
`default_nettype none
module desr_responder #(
  parameter logic [7:0] DEVICE_TYPE = 8'h5a, // Arbitrary value
  parameter logic [3:0] FRU_LATCH = desr_pkg::FRU_LATCH_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tag_unit_sel,
  input wire logic i_tag_sector,
  input wire logic i_tag_ext,
  input wire logic [9:0] i_bus_out,
  input wire logic [7:0] i_logical_addr,
  input wire logic [7:0] i_own_addr,
  input wire logic i_deselect,
  input wire logic [6:0] i_fault_bits,
  input wire logic [6:0] i_oper_status,
  input wire logic [3:0] i_fru_sel,
  input wire logic i_diag_running,
  output logic [7:0] o_bus_in,
  output logic o_bus_in_oe,
  output logic o_unit_selected,
  output logic o_selection_latch
);
  desr_pkg::desr_ctl_s ctl_m_q, ctl_q;
  desr_pkg::desr_fault_s flt_m_q, flt_q;
  logic [7:0] addr_m_q, addr_q;
  logic [6:0] oper_m_q, oper_q;
  logic [3:0] fru_m_q, fru_q;
  logic desel_m_q, desel_q, diag_m_q, diag_q;
  logic [7:0] own_m_q, own_q;
  logic [7:0] bus_in_d, bus_in_q;
  logic oe_d, oe_q, usel_q, sel_q;

  // Two-stage synchronisers on every pin input, one short block per group
  // Tags and bus out
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctl_m_q <= '0;
      ctl_q <= '0;
    end else begin
      ctl_m_q <= {i_tag_unit_sel, i_tag_sector, i_tag_ext, i_bus_out};
      ctl_q <= ctl_m_q;
    end
  end

  // Fault latches
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flt_m_q <= '0;
      flt_q <= '0;
    end else begin
      flt_m_q <= i_fault_bits;
      flt_q <= flt_m_q;
    end
  end

  // Address sent by the controller
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      addr_m_q <= 8'h00;
      addr_q <= 8'h00;
    end else begin
      addr_m_q <= i_logical_addr;
      addr_q <= addr_m_q;
    end
  end

  // Address switches are pins too, so they pass the same two stages
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      own_m_q <= 8'h00;
      own_q <= 8'h00;
    end else begin
      own_m_q <= i_own_addr;
      own_q <= own_m_q;
    end
  end

  // Operating status
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      oper_m_q <= 7'h00;
      oper_q <= 7'h00;
    end else begin
      oper_m_q <= i_oper_status;
      oper_q <= oper_m_q;
    end
  end

  // Likeliest failed unit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fru_m_q <= 4'h0;
      fru_q <= 4'h0;
    end else begin
      fru_m_q <= i_fru_sel;
      fru_q <= fru_m_q;
    end
  end

  // Deselect request
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      desel_m_q <= 1'b0;
      desel_q <= 1'b0;
    end else begin
      desel_m_q <= i_deselect;
      desel_q <= desel_m_q;
    end
  end

  // Diagnostic test running
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      diag_m_q <= 1'b0;
      diag_q <= 1'b0;
    end else begin
      diag_m_q <= i_diag_running;
      diag_q <= diag_m_q;
    end
  end

  // Decode; own address is a static switch setting
  wire logic addr_match = ctl_q.tag_unit_sel && (addr_q == own_q);
  wire logic type_tag = ctl_q.tag_ext && ctl_q.tag_sector;
  wire logic ext_tag = ctl_q.tag_ext && !ctl_q.tag_sector;
  // Only bits 1:0 select the view; bits 9:2 are not decoded
  wire logic [1:0] view = ctl_q.bus_out[1:0];
  wire logic [6:0] fault_view = {flt_q.voltage, flt_q.head_sel, flt_q.write_prot,
    flt_q.write_flt, flt_q.first_seek, flt_q.off_cyl, flt_q.rd_and_wr};

  // Unit code table; unlisted selections report no code
  logic [3:0] fru_code;
  always_comb begin
    unique case (fru_q)
      desr_pkg::FRU_POWER, desr_pkg::FRU_CONTROL, desr_pkg::FRU_RW,
      desr_pkg::FRU_MODULE, desr_pkg::FRU_FAN, desr_pkg::FRU_IO,
      desr_pkg::FRU_PANEL, FRU_LATCH: fru_code = fru_q;
      default: fru_code = desr_pkg::FRU_NONE;
    endcase
  end

  // Execute view is answered whenever asked, bit 7 carrying the diagnostic-running flag; spindle gating is the controller's duty
  always_comb begin
    bus_in_d = desr_pkg::BUS_IN_RST;
    unique case (view)
      desr_pkg::VIEW_FAULT: bus_in_d = {1'b1, fault_view};
      desr_pkg::VIEW_OPER: bus_in_d = {1'b1, oper_q};
      desr_pkg::VIEW_DIAG: bus_in_d = {1'b1, 3'h0, fru_code};
      desr_pkg::VIEW_EXEC: bus_in_d = {diag_q, 7'h00};
    endcase
    if (type_tag) begin
      bus_in_d = DEVICE_TYPE;
    end
    oe_d = sel_q && (ext_tag || type_tag);
    if (!oe_d) begin
      bus_in_d = desr_pkg::BUS_IN_RST;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sel_q <= 1'b0;
      usel_q <= 1'b0;
      bus_in_q <= desr_pkg::BUS_IN_RST;
      oe_q <= 1'b0;
    end else begin
      // Match wins over a deselect in the same cycle
      if (addr_match) begin
        sel_q <= 1'b1;
      end else if (desel_q) begin
        sel_q <= 1'b0;
      end
      usel_q <= addr_match;
      bus_in_q <= bus_in_d;
      oe_q <= oe_d;
    end
  end

  assign o_bus_in = bus_in_q;
  assign o_bus_in_oe = oe_q;
  assign o_unit_selected = usel_q;
  assign o_selection_latch = sel_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Fault view
  fault_view_a: assert property (sel_q && ext_tag && view == desr_pkg::VIEW_FAULT
    |=> o_bus_in == {1'b1, $past(fault_view)} && o_bus_in_oe)
    else $error("fault view wrong");
  fault_low_a: assert property (oe_d && !type_tag && view == 2'h0
    |=> o_bus_in[2:0] == $past({flt_q.first_seek, flt_q.off_cyl, flt_q.rd_and_wr}))
    else $error("fault low bits wrong");
  fault_high_a: assert property (oe_d && !type_tag && view == 2'h0
    |=> o_bus_in[6:3] == $past({flt_q.voltage, flt_q.head_sel, flt_q.write_prot,
    flt_q.write_flt}))
    else $error("fault high bits wrong");

  // Each fault input lands on its own inbound bit
  for (genvar b = 0; b < 7; b++) begin : g_fault_bit
    fault_bit_a: assert property (oe_d && !type_tag && view == 2'h0
      |=> o_bus_in[b] == $past(flt_q[b]))
      else $error("fault bit wrong");
  end : g_fault_bit

  // Valid bit and the other views
  valid_bit_a: assert property (oe_d && !type_tag && view != 2'h3
    |=> o_bus_in[7])
    else $error("valid bit missing");
  oper_view_a: assert property (oe_d && !type_tag && view == 2'h1
    |=> o_bus_in[6:0] == $past(oper_q))
    else $error("operating view wrong");
  oper_valid_a: assert property (oe_d && !type_tag && view == 2'h1
    |=> o_bus_in[7])
    else $error("operating valid missing");
  diag_view_a: assert property (oe_d && !type_tag && view == 2'h2
    |=> o_bus_in[3:0] == $past(fru_code))
    else $error("diagnostic code wrong");
  diag_valid_a: assert property (oe_d && !type_tag && view == 2'h2
    |=> o_bus_in[7])
    else $error("diagnostic valid missing");
  fru_table_a: assert property (fru_q == 4'h3 |-> fru_code == 4'h0)
    else $error("unused code reported");
  diag_pad_a: assert property (oe_d && !type_tag && view == 2'h2
    |=> o_bus_in[6:4] == 3'h0)
    else $error("diagnostic pad wrong");
  exec_view_a: assert property (oe_d && !type_tag && view == 2'h3
    |=> o_bus_in[7] == $past(diag_q))
    else $error("execute flag wrong");
  exec_low_a: assert property (oe_d && !type_tag && view == 2'h3
    |=> o_bus_in[6:0] == 7'h00)
    else $error("execute low bits wrong");

  // Device type
  type_view_a: assert property (sel_q && type_tag |=> o_bus_in == DEVICE_TYPE)
    else $error("device type wrong");
  type_oe_a: assert property (sel_q && type_tag |=> o_bus_in_oe)
    else $error("device type not driven");

  // Selection
  match_sel_a: assert property (addr_match |=> o_unit_selected && o_selection_latch)
    else $error("select missing");
  usel_drop_a: assert property (!addr_match |=> !o_unit_selected)
    else $error("unit selected without match");
  latch_hold_a: assert property (o_selection_latch && !desel_q |=> o_selection_latch)
    else $error("latch dropped");
  desel_clear_a: assert property (desel_q && !addr_match |=> !o_selection_latch)
    else $error("latch not cleared");
  latch_idle_a: assert property (!o_selection_latch && !addr_match |=> !o_selection_latch)
    else $error("latch set without match");
  usel_latch_a: assert property (o_unit_selected |-> o_selection_latch)
    else $error("selected without latch");

  // Bus drivers
  release_a: assert property (!sel_q |=> !o_bus_in_oe && o_bus_in == 8'h00)
    else $error("bus driven unselected");
  drive_need_a: assert property (o_bus_in_oe |-> $past(sel_q))
    else $error("drove without latch");
  tag_need_a: assert property (!ext_tag && !type_tag |=> !o_bus_in_oe)
    else $error("drove without tag");
  oe_follow_a: assert property (oe_d |=> o_bus_in_oe)
    else $error("drivers not enabled");

  sel_c: cover property (addr_match ##1 o_selection_latch);
  fault_c: cover property (o_bus_in_oe && view == 2'h0 && |o_bus_in[6:0]);
  diag_c: cover property (o_bus_in_oe && view == 2'h2 && fru_code != desr_pkg::FRU_NONE);
  exec_c: cover property (oe_d && view == 2'h3 && diag_q);
  type_c: cover property (sel_q && type_tag);
endmodule : desr_responder
`default_nettype wire

// ### sim/desr_ctl_model.sv
// Controller-side model driving the tags, bus out and logical address
`timescale 1ns/10ps
`default_nettype none
module desr_ctl_model (
  input wire logic i_clk,
  output var desr_pkg::desr_ctl_s o_ctl,
  output var logic [7:0] o_addr
);
  initial begin
    o_ctl = '0;
    o_addr = 8'hff;
  end
  // Never asks for the execute view with the spindle down
  // Never uses extended addressing, so the device-type tag is legal
  task automatic drive(input logic us, input logic sec, input logic ext, input logic [1:0] v,
                       input logic [7:0] a);
    @(negedge i_clk);
    o_ctl.tag_unit_sel = us;
    o_ctl.tag_sector = sec;
    o_ctl.tag_ext = ext;
    o_ctl.bus_out = {8'h00, v};
    o_addr = us ? a : ~a;
    repeat (4) @(posedge i_clk);
    #1;
  endtask : drive
endmodule : desr_ctl_model
`default_nettype wire

// ### sim/desr_responder_tb_top.sv
// Self-checking bench for the extended-status responder
`timescale 1ns/10ps
`default_nettype none
module desr_responder_tb_top;
  logic i_clk, i_rst, dsel, run;
  logic [6:0] flt, opr;
  logic [3:0] fru, cd;
  logic [7:0] addr, bus_in;
  logic oe, usel, latch;
  desr_pkg::desr_ctl_s ctl;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  desr_ctl_model m (.i_clk(i_clk), .o_ctl(ctl), .o_addr(addr));
  desr_responder #(.DEVICE_TYPE(8'h3c)) i_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_tag_unit_sel(ctl.tag_unit_sel), .i_tag_sector(ctl.tag_sector), .i_tag_ext(ctl.tag_ext),
    .i_bus_out(ctl.bus_out), .i_logical_addr(addr), .i_own_addr(8'h2d), .i_deselect(dsel),
    .i_fault_bits(flt), .i_oper_status(opr), .i_fru_sel(fru), .i_diag_running(run),
    .o_bus_in(bus_in), .o_bus_in_oe(oe), .o_unit_selected(usel), .o_selection_latch(latch));
  task automatic print_verdict();
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  // Compares {unit selected, latch, output enable, bus in}
  task automatic chk(input logic [10:0] e);
    n_tests++;
    if ({usel, latch, oe, bus_in} !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, {usel, latch, oe, bus_in}, e);
    end
  endtask : chk
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    i_rst = 1'b1;
    dsel = 1'b0;
    run = 1'b0;
    flt = 7'h55;
    opr = 7'h2a;
    fru = 4'h0;
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    m.drive(1'b0, 1'b0, 1'b1, 2'h0, 8'h2d);
    chk(11'h000);
    m.drive(1'b1, 1'b0, 1'b0, 2'h0, 8'h2c);
    chk(11'h000);
    m.drive(1'b1, 1'b0, 1'b0, 2'h0, 8'h2d);
    chk({3'b110, 8'h00});
    m.drive(1'b0, 1'b0, 1'b0, 2'h0, 8'h2d);
    chk({3'b010, 8'h00});
    for (int i = 0; i < 7; i++) begin
      @(negedge i_clk);
      flt = 7'h01 << i;
      m.drive(1'b0, 1'b0, 1'b1, 2'h0, 8'h00);
      chk({3'b011, 1'b1, flt});
    end
    m.drive(1'b0, 1'b0, 1'b1, 2'h1, 8'h00);
    chk({3'b011, 1'b1, opr});
    for (int c = 0; c < 16; c++) begin
      @(negedge i_clk);
      fru = 4'(c);
      cd = (c inside {1, 2, 4, 5, 6, 7, 8, 9}) ? 4'(c) : 4'h0;
      m.drive(1'b0, 1'b0, 1'b1, 2'h2, 8'h00);
      chk({3'b011, 4'h8, cd});
    end
    for (int r = 0; r < 2; r++) begin
      @(negedge i_clk);
      run = 1'(r);
      m.drive(1'b0, 1'b0, 1'b1, 2'h3, 8'h00);
      chk({3'b011, run, 7'h00});
    end
    m.drive(1'b0, 1'b1, 1'b1, 2'h0, 8'h00);
    chk({3'b011, 8'h3c});
    @(negedge i_clk);
    dsel = 1'b1;
    m.drive(1'b0, 1'b0, 1'b1, 2'h0, 8'h00);
    chk(11'h000);
    print_verdict();
  end
endmodule : desr_responder_tb_top
`default_nettype wire
